// [hw/clk_source_select.sv]
/*
  clk_source_select: picks and derives the system clock level from the
  wakeup source, the external clock pin, a prescaled oscillator or a
  digital model of the multiplying loop; registers over AXI4-Lite.
  assumes: all clock source inputs are levels sampled by sys_clk, so any
  derived clock is at most half of sys_clk.
*/
// Decided for this implementation: register access over AXI4-Lite and the address map.
// Behaviour
// - code 11 passes external clock pin through
// - code 10, bypass 1: prescale the oscillator
// - factor one passes oscillator level unchanged
// - prescaler divides by up to 1024
// - code 10, bypass 0: loop drives system clock
// - loop gives input times N/(P*divider)
// - loop reference from crystal or internal source
// - output divider scales the loop period
// - loop frequency slews gradually, but jumps at once when N is rewritten
// - band 00 low, 01 high, 1x reserved
// - code 00 uses wakeup source directly
`timescale 1ns/1ps
module clk_source_select #(
  parameter int P_W = 4,
  parameter int N_W = 7,
  parameter int OUTDIV_W = 7,
  parameter int PRESC_W = 10,
  parameter int PER_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input clk_sel_pkg::axi_req_t axiReq,
  output clk_sel_pkg::axi_rsp_t axiRsp,
  // clock sources
  input wire logic externalClockPin,
  input wire logic crystalInputPin,
  input wire logic internalClkSrc,
  input wire logic wakeupClkSrc,
  // derived clock and status
  output logic sysClkOut,
  output logic loopLocked,
  output logic [1:0] oscBandOut
);
  localparam int DEN_W = PER_W + OUTDIV_W;
  localparam int ACC_W = DEN_W + N_W + 2;

  if (PRESC_W < 10 || PRESC_W > 16 || P_W < 1 || N_W < 1 || OUTDIV_W < 1 || PER_W < 4 ||
      P_W + N_W > 16 || OUTDIV_W > 8) begin : g_bad_params
    $error("clk_source_select: unsupported field widths");
  end

  typedef struct packed {
    logic awHave;
    logic [clk_sel_pkg::ADDR_W-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [1:0] srcSel;
    logic bypass;
    logic [1:0] band;
    logic refSel;
    logic [P_W-1:0] input_divider_field;
    logic [N_W-1:0] feedback_multiplier_field;
    logic [OUTDIV_W-1:0] outDiv;
    logic [PRESC_W-1:0] prescDiv;
    logic oscPrev;
    logic [PRESC_W-1:0] presCnt;
    logic presOut;
    logic [P_W-1:0] refCnt;
    logic refSeen;
    logic [PER_W-1:0] perCnt;
    logic [PER_W-1:0] perMeas;
    logic [DEN_W-1:0] denCur;
    logic [ACC_W-1:0] acc;
    logic loopOut;
    logic locked;
    logic sysClk;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [31:0] loopWord;
  logic [31:0] sysWord;
  logic [31:0] prescWord;
  logic [31:0] statWord;

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    sysWord = '0;
    sysWord[clk_sel_pkg::SYS_SRC_LSB +: 2] = s_q.srcSel;
    loopWord = '0;
    loopWord[clk_sel_pkg::LOOP_BYPASS_BIT] = s_q.bypass;
    loopWord[clk_sel_pkg::LOOP_BAND_LSB +: 2] = s_q.band;
    loopWord[clk_sel_pkg::LOOP_REF_BIT] = s_q.refSel;
    loopWord[clk_sel_pkg::LOOP_INDIV_LSB +: P_W] = s_q.input_divider_field;
    loopWord[clk_sel_pkg::LOOP_MULT_LSB +: N_W] = s_q.feedback_multiplier_field;
    loopWord[clk_sel_pkg::LOOP_OUTDIV_LSB +: OUTDIV_W] = s_q.outDiv;
    prescWord = '0;
    prescWord[clk_sel_pkg::PRESC_LSB +: PRESC_W] = s_q.prescDiv;
    statWord = '0;
    statWord[clk_sel_pkg::STAT_LOCK_BIT] = s_q.locked;
    statWord[clk_sel_pkg::STAT_SRC_LSB +: 2] = s_q.srcSel;
    statWord[clk_sel_pkg::STAT_CLK_BIT] = s_q.sysClk;
    statWord[clk_sel_pkg::STAT_BAND_LSB +: 2] = s_q.band;
  end

  always_comb begin
    logic [31:0] wr;
    logic osc;
    logic oscRise;
    logic refTick;
    logic loopOn;
    logic presSel;
    logic [PRESC_W:0] presHalf;
    logic [DEN_W-1:0] target;
    logic [DEN_W-1:0] diff;
    logic [DEN_W-1:0] step;
    logic [ACC_W-1:0] accSum;
    logic [ACC_W-1:0] den;
    wr = '0;
    osc = '0;
    oscRise = '0;
    refTick = '0;
    loopOn = '0;
    presSel = '0;
    presHalf = '0;
    target = '0;
    diff = '0;
    step = '0;
    accSum = '0;
    den = '0;
    s_d = s_q;

    // bus: address and data are taken in either order
    if (axiReq.awvalid && axiRsp.awready) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      s_d.wHave = 1'b1;
      s_d.wData = axiReq.wdata;
      s_d.wStrb = axiReq.wstrb;
    end
    if (s_q.bValid && axiReq.bready) begin
      s_d.bValid = 1'b0;
    end
    if (s_q.awHave && s_q.wHave && !s_q.bValid) begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = clk_sel_pkg::RESP_OKAY;
      unique case ({s_q.awAddr[clk_sel_pkg::ADDR_W-1:2], 2'h0})
        clk_sel_pkg::OFF_SYS_CFG: begin
          wr = mergeStrb(sysWord, s_q.wData, s_q.wStrb);
          if (wr[clk_sel_pkg::SYS_SRC_LSB +: 2] != clk_sel_pkg::SRC_RSVD) begin
            s_d.srcSel = wr[clk_sel_pkg::SYS_SRC_LSB +: 2];
          end
        end
        clk_sel_pkg::OFF_LOOP_CFG: begin
          wr = mergeStrb(loopWord, s_q.wData, s_q.wStrb);
          s_d.bypass = wr[clk_sel_pkg::LOOP_BYPASS_BIT];
          // reserved band codes are dropped so the oscillator never leaves its range
          if (!wr[clk_sel_pkg::LOOP_BAND_LSB + 1]) begin
            s_d.band = wr[clk_sel_pkg::LOOP_BAND_LSB +: 2];
          end
          s_d.refSel = wr[clk_sel_pkg::LOOP_REF_BIT];
          s_d.input_divider_field = wr[clk_sel_pkg::LOOP_INDIV_LSB +: P_W];
          s_d.feedback_multiplier_field = wr[clk_sel_pkg::LOOP_MULT_LSB +: N_W];
          s_d.outDiv = wr[clk_sel_pkg::LOOP_OUTDIV_LSB +: OUTDIV_W];
        end
        clk_sel_pkg::OFF_PRESC: begin
          wr = mergeStrb(prescWord, s_q.wData, s_q.wStrb);
          s_d.prescDiv = wr[clk_sel_pkg::PRESC_LSB +: PRESC_W];
        end
        clk_sel_pkg::OFF_STATUS: begin
          s_d.bResp = clk_sel_pkg::RESP_OKAY;
        end
        default: begin
          s_d.bResp = clk_sel_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (s_q.rValid && axiReq.rready) begin
      s_d.rValid = 1'b0;
    end
    if (axiReq.arvalid && axiRsp.arready) begin
      s_d.rValid = 1'b1;
      s_d.rResp = clk_sel_pkg::RESP_OKAY;
      unique case ({axiReq.araddr[clk_sel_pkg::ADDR_W-1:2], 2'h0})
        clk_sel_pkg::OFF_SYS_CFG: s_d.rData = sysWord;
        clk_sel_pkg::OFF_LOOP_CFG: s_d.rData = loopWord;
        clk_sel_pkg::OFF_PRESC: s_d.rData = prescWord;
        clk_sel_pkg::OFF_STATUS: s_d.rData = statWord;
        default: begin
          s_d.rData = '0;
          s_d.rResp = clk_sel_pkg::RESP_SLVERR;
        end
      endcase
    end

    // one oscillator source feeds both prescaler and loop
    osc = s_q.refSel ? internalClkSrc : crystalInputPin;
    oscRise = osc && !s_q.oscPrev;
    s_d.oscPrev = osc;

    // prescaler: high for the first ceil(K1/2) source periods
    if (oscRise) begin
      s_d.presCnt = (s_q.presCnt >= s_q.prescDiv) ? '0 : s_q.presCnt + 1'b1;
    end
    presHalf = ({1'b0, s_q.prescDiv} + 2'd2) >> 1;
    s_d.presOut = {1'b0, s_d.presCnt} < presHalf;
    // factor one follows the source level, keeping its duty cycle
    presSel = (s_q.prescDiv == '0) ? osc : s_q.presOut;

    // loop model: measure the reference after P, output period den/N cycles
    loopOn = (s_q.srcSel == clk_sel_pkg::SRC_OSC) && !s_q.bypass;
    if (oscRise) begin
      s_d.refCnt = (s_q.refCnt >= s_q.input_divider_field) ? '0 : s_q.refCnt + 1'b1;
      refTick = (s_q.refCnt >= s_q.input_divider_field);
    end
    s_d.perCnt = refTick ? PER_W'(1) :
                 ((&s_q.perCnt) ? s_q.perCnt : s_q.perCnt + 1'b1);
    if (refTick) begin
      s_d.refSeen = 1'b1;
      if (s_q.refSeen) begin
        s_d.perMeas = s_q.perCnt;
      end
    end
    // output divider lengthens the period: div*T sys_clk cycles per N outputs
    target = DEN_W'(s_q.perMeas) * DEN_W'({1'b0, s_q.outDiv} + 1'b1);
    if (!loopOn) begin
      // restart from the slowest rate so enabling never jumps up
      s_d.denCur = '1;
      s_d.acc = '0;
      s_d.loopOut = 1'b0;
      s_d.locked = 1'b0;
    end else begin
      if (refTick && s_q.perMeas != '0) begin
        if (s_q.denCur > target) begin
          diff = s_q.denCur - target;
          step = (diff >> clk_sel_pkg::SLEW_SHIFT) + 1'b1;
          s_d.denCur = s_q.denCur - step;
        end else if (s_q.denCur < target) begin
          diff = target - s_q.denCur;
          step = (diff >> clk_sel_pkg::SLEW_SHIFT) + 1'b1;
          s_d.denCur = s_q.denCur + step;
        end
      end
      s_d.locked = (s_q.denCur == target) && (s_q.perMeas != '0);
      // two toggles per output cycle: add 2N, toggle each den crossed
      den = ACC_W'(s_q.denCur);
      accSum = s_q.acc + ACC_W'({s_q.feedback_multiplier_field, 1'b0}) + ACC_W'(2);
      if (accSum >= den) begin
        s_d.loopOut = !s_q.loopOut;
        // capped at half of sys_clk; excess phase is dropped
        s_d.acc = (accSum - den >= den) ? '0 : accSum - den;
      end else begin
        s_d.acc = accSum;
      end
    end

    unique case (s_q.srcSel)
      clk_sel_pkg::SRC_WAKEUP: s_d.sysClk = wakeupClkSrc;
      clk_sel_pkg::SRC_OSC: s_d.sysClk = s_q.bypass ? presSel : s_q.loopOut;
      clk_sel_pkg::SRC_DIRECT: s_d.sysClk = externalClockPin;
      default: s_d.sysClk = s_q.sysClk;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.srcSel <= clk_sel_pkg::RST_SRC;
      s_q.bypass <= clk_sel_pkg::RST_BYPASS;
      s_q.band <= clk_sel_pkg::RST_BAND;
      s_q.refSel <= clk_sel_pkg::RST_REF;
      s_q.denCur <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    axiRsp.awready = !s_q.awHave && !s_q.bValid;
    axiRsp.wready = !s_q.wHave && !s_q.bValid;
    axiRsp.bvalid = s_q.bValid;
    axiRsp.bresp = s_q.bResp;
    axiRsp.arready = !s_q.rValid;
    axiRsp.rvalid = s_q.rValid;
    axiRsp.rdata = s_q.rData;
    axiRsp.rresp = s_q.rResp;
  end

  assign sysClkOut = s_q.sysClk;
  assign loopLocked = s_q.locked;
  assign oscBandOut = s_q.band;
endmodule // clk_source_select

// [hw/clk_sel_pkg.sv]
/*
  clk_sel_pkg: register map, field layout, codes and reset values of the
  system clock source selector.
  assumes: 32-bit AXI4-Lite register bus, byte addresses as given here.
*/
package clk_sel_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SYS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LOOP_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRESC = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  // field positions
  localparam int SYS_SRC_LSB = 0;
  localparam int LOOP_BYPASS_BIT = 0;
  localparam int LOOP_BAND_LSB = 1;
  localparam int LOOP_REF_BIT = 3;
  localparam int LOOP_INDIV_LSB = 4;
  localparam int LOOP_MULT_LSB = 8;
  localparam int LOOP_OUTDIV_LSB = 16;
  localparam int PRESC_LSB = 0;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_SRC_LSB = 1;
  localparam int STAT_CLK_BIT = 3;
  localparam int STAT_BAND_LSB = 4;
  // clock source codes
  localparam logic [1:0] SRC_WAKEUP = 2'h0;
  localparam logic [1:0] SRC_RSVD = 2'h1;
  localparam logic [1:0] SRC_OSC = 2'h2;
  localparam logic [1:0] SRC_DIRECT = 2'h3;
  // oscillator band codes; 1x reserved
  localparam logic [1:0] BAND_LOW = 2'h0;
  localparam logic [1:0] BAND_HIGH = 2'h1;
  // reset values
  localparam logic [1:0] RST_SRC = SRC_WAKEUP;
  localparam logic RST_BYPASS = 1'b1;
  localparam logic [1:0] RST_BAND = BAND_LOW;
  localparam logic RST_REF = 1'b0;
  // loop slew: step is one eighth of the remaining error plus one
  localparam int SLEW_SHIFT = 3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;
endpackage

// [test/clk_sel_asserts.sv]
/*
  clk_sel_asserts: checker for the clock source selector, bus handshakes,
  reset state and band code.
  assumes: bound to clk_source_select, one clock domain.
*/
`timescale 1ns/1ps
module clk_sel_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input clk_sel_pkg::axi_req_t axiReq,
  input clk_sel_pkg::axi_rsp_t axiRsp,
  // derived outputs
  input wire logic sysClkOut,
  input wire logic loopLocked,
  input wire logic [1:0] oscBandOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_write_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |-> ##2 axiRsp.bvalid) else $error("write not answered");
  a_bresp_stands: assert property (axiRsp.bvalid && !axiReq.bready
    |=> axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("write answer dropped");
  a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read not answered");
  a_rdata_stands: assert property (axiRsp.rvalid && !axiReq.rready
    |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read answer dropped");
  a_read_refused: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read taken while answering");
  a_unmapped_read: assert property (axiReq.arvalid && axiRsp.arready && axiReq.araddr >= 8'h10
    |=> axiRsp.rresp == clk_sel_pkg::RESP_SLVERR && axiRsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_band_legal: assert property (!oscBandOut[1]) else $error("reserved band held");
  a_reset_quiet: assert property ($fell(rst) |-> !sysClkOut && !loopLocked
    && oscBandOut == 2'h0 && !axiRsp.bvalid) else $error("bad state after reset");
  cover property (axiRsp.bvalid && axiReq.bready);
  cover property ($rose(loopLocked));
  cover property (axiRsp.rvalid && axiRsp.rresp == clk_sel_pkg::RESP_SLVERR);
endmodule // clk_sel_asserts
bind clk_source_select clk_sel_asserts clk_sel_asserts_i (.sys_clk, .rst, .axiReq, .axiRsp,
  .sysClkOut, .loopLocked, .oscBandOut);

// [test/clk_src_model.sv]
/*
  clk_src_model: free running clock sources around the selector.
  assumes: levels change just after sys_clk rising edges.
*/
`timescale 1ns/1ps
module clk_src_model (
  // clock
  input wire logic sys_clk,
  // source levels
  output logic extPin,
  output logic xtal,
  output logic intSrc,
  output logic wakeSrc
);
  logic [3:0] cntQ;
  logic [2:0] sixQ;
  initial begin
    cntQ = 4'h0;
    sixQ = 3'h0;
  end
  always @(posedge sys_clk) begin
    cntQ <= cntQ + 4'h1;
    sixQ <= (sixQ == 3'h5) ? 3'h0 : sixQ + 3'h1;
  end
  // uneven duty on extPin so a pass-through is told apart from a divider
  assign extPin = cntQ[0] & cntQ[2];
  assign xtal = cntQ[1];
  assign intSrc = (sixQ >= 3'h3);
  assign wakeSrc = cntQ[3];
endmodule // clk_src_model

// [test/tb_top.sv]
/*
  tb_top: self-checking bench for the clock source selector.
  assumes: crystal period 4, internal period 6 sys_clk cycles.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic sys_clk, rst, extPin, xtal, intSrc, wakeSrc, sysClkOut, loopLocked;
  logic [1:0] oscBandOut;
  logic [33:0] q;
  clk_sel_pkg::axi_req_t req;
  clk_sel_pkg::axi_rsp_t rsp;
  int miscompares, nTests, k, p, n;
  clk_source_select clk_source_select_i (.sys_clk(sys_clk), .rst(rst), .axiReq(req),
    .axiRsp(rsp), .externalClockPin(extPin), .crystalInputPin(xtal), .internalClkSrc(intSrc),
    .wakeupClkSrc(wakeSrc), .sysClkOut(sysClkOut), .loopLocked(loopLocked),
    .oscBandOut(oscBandOut));
  clk_src_model clk_src_model_i (.sys_clk(sys_clk), .extPin(extPin), .xtal(xtal),
    .intSrc(intSrc), .wakeSrc(wakeSrc));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one transfer; ready late on purpose so the read answer must stand
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [33:0] r);
    logic aw, wd, ar, done;
    if (w) begin
      req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.awaddr <= a; req.wdata <= d;
      req.wstrb <= 4'hF;
    end else begin
      req.arvalid <= 1'b1; req.araddr <= a;
    end
    for (int i = 0; i < 50; i++) begin
      @(negedge sys_clk);
      aw = req.awvalid & rsp.awready; wd = req.wvalid & rsp.wready;
      ar = req.arvalid & rsp.arready;
      done = w ? (rsp.bvalid & req.bready) : (rsp.rvalid & req.rready);
      r = w ? {rsp.bresp, 32'h0} : {rsp.rresp, rsp.rdata};
      @(posedge sys_clk);
      if (aw) req.awvalid <= 1'b0;
      if (wd) req.wvalid <= 1'b0;
      if (ar) req.arvalid <= 1'b0;
      if (done) begin
        req.bready <= 1'b0; req.rready <= 1'b0;
        return;
      end
      if (i >= 1) begin
        req.bready <= w; req.rready <= !w;
      end
    end
    miscompares++;
    wrap_up();
  endtask
  function automatic logic lvl(int s);
    return s == 0 ? wakeSrc : s == 1 ? extPin : xtal;
  endfunction
  // expected loop period: ref period * P * divider / N
  function automatic int loopPer(bit r, int pm, int nm, int km);
    return (r ? 6 : 4) * (pm + 1) * (km + 1) / (nm + 1);
  endfunction
  function automatic logic [31:0] loopWord(bit r, int pm, int nm, int km, int band);
    return 32'(km) << 16 | 32'(nm) << 8 | 32'(pm) << 4 | 32'(r) << 3 | 32'(band) << 1;
  endfunction
  task automatic follow(int s);
    logic e;
    @(negedge sys_clk);
    e = lvl(s);
    repeat (16) begin
      @(negedge sys_clk);
      `CHK(sysClkOut, e)
      e = lvl(s);
    end
    @(posedge sys_clk);
  endtask
  task automatic rise(inout int c);
    while (sysClkOut !== 1'b0 && c < 9000) begin @(negedge sys_clk); c++; end
    while (sysClkOut !== 1'b1 && c < 9000) begin @(negedge sys_clk); c++; end
  endtask
  task automatic per(output int pr);
    int c;
    c = 0; rise(c); rise(c);
    c = 0; rise(c);
    pr = c;
    @(posedge sys_clk);
  endtask
  initial begin
    rst = 1'b1; req = '0; miscompares = 0; nTests = 0;
    void'($urandom(55));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, clk_sel_pkg::OFF_SYS_CFG, 32'h0, q); `CHK(q, 34'h0)
    bus(0, clk_sel_pkg::OFF_LOOP_CFG, 32'h0, q); `CHK(q, 34'h1)
    bus(0, 8'h10, 32'h0, q); `CHK(q, {clk_sel_pkg::RESP_SLVERR, 32'h0})
    bus(1, 8'h14, 32'hFFFF_FFFF, q); `CHK(q[33:32], clk_sel_pkg::RESP_SLVERR)
    follow(0);
    bus(1, clk_sel_pkg::OFF_SYS_CFG, 32'h3, q);
    follow(1);
    bus(1, clk_sel_pkg::OFF_SYS_CFG, 32'h1, q);
    bus(0, clk_sel_pkg::OFF_SYS_CFG, 32'h0, q); `CHK(q, 34'h3)
    follow(1);
    bus(1, clk_sel_pkg::OFF_LOOP_CFG, 32'h1, q);
    bus(1, clk_sel_pkg::OFF_PRESC, 32'h0, q);
    bus(1, clk_sel_pkg::OFF_SYS_CFG, 32'h2, q);
    follow(2);
    for (int i = 0; i < 4; i++) begin
      k = (i == 3) ? 1024 : 2 + $urandom % 8;
      bus(1, clk_sel_pkg::OFF_PRESC, 32'(k - 1), q);
      per(p); `CHK(p, 4 * k)
    end
    // whole loop setup in one write, no half-programmed rate
    bus(1, clk_sel_pkg::OFF_LOOP_CFG, loopWord(0, 0, 1, 3, 1) & ~32'h1, q);
    for (int i = 0; i < 3; i++) begin
      if (i == 1) bus(1, clk_sel_pkg::OFF_LOOP_CFG, loopWord(1, 0, 2, 3, 2), q);
      if (i == 2) bus(1, clk_sel_pkg::OFF_LOOP_CFG, loopWord(0, 0, 0, 2, 0), q);
      `CHK(oscBandOut, (i == 2) ? 2'h0 : 2'h1)
      // lock bit is stale until the new reference period is measured
      repeat (40) @(posedge sys_clk);
      n = 0;
      while (loopLocked !== 1'b1 && n < 4000) begin @(posedge sys_clk); n++; end
      `CHK(loopLocked, 1'b1)
      per(p);
      if (i == 0) `CHK(p, loopPer(0, 0, 1, 3))
      if (i == 1) `CHK(p, loopPer(1, 0, 2, 3))
      if (i == 2) `CHK(p, loopPer(0, 0, 0, 2))
    end
    bus(0, clk_sel_pkg::OFF_STATUS, 32'h0, q); `CHK(q[0], 1'b1)
    wrap_up();
  end
endmodule // tb_top
